// ---- hwl_defines.svh ----
// hwl_defines.svh: offsets, field positions, reset values and counts
// for the hardware loop stacks.
// assumes: included by bare name after the package is compiled.
`ifndef HWL_DEFINES_SVH
`define HWL_DEFINES_SVH

// ==========================================================
// stack geometry
`define HWL_DEPTH        6
`define HWL_WIDTH        32
`define HWL_PTR_W        3

// ==========================================================
// register word offsets (byte addresses)
`define HWL_OFS_END_TOP  8'h00
`define HWL_OFS_CUR_CNT  8'h04
`define HWL_OFS_PEND_CNT 8'h08
`define HWL_OFS_STATUS   8'h0c
`define HWL_OFS_DEPTH    8'h10

// ==========================================================
// status fields and reset values
`define HWL_BIT_OVF      25
`define HWL_BIT_EMPTY    26
`define HWL_ALL_ONES     32'hffffffff
`define HWL_PEND_RST     32'h00000000

// ==========================================================
// short loop timing
`define HWL_NOP_CYCLES   2'h2
`define HWL_COND_EXTRA1  2'h3
`define HWL_COND_EXTRA1P 2'h2

`endif

// ---- hwl_pkg.sv ----
// hwl_pkg.sv: types shared by the hardware loop stack files.
// assumes: nothing beyond a SystemVerilog compiler.
package hwl_pkg;

  // how long the loop body is, in instructions
  typedef logic [1:0] hwl_len_t;

  // short loop tracking states, one-hot
  typedef enum logic [2:0]
  {
    HWL_IDLE = 3'b001,
    HWL_RUN  = 3'b010,
    HWL_NOPS = 3'b100
  } hwl_state_e;

endpackage

// ---- hwl_short_loop.sv ----
// hwl_short_loop.sv: pipeline timing for short loops: nop insertion,
// interrupt delay and extra iterations after a condition turns true.
// assumes: strobes from the sequencer are one-cycle pulses on clock.
`timescale 1ns/1ns
`default_nettype none

`include "hwl_defines.svh"

module hwl_short_loop
  import hwl_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            srst,
  input  wire logic            loop_start,
  input  wire logic [1:0]      loop_len,
  input  wire logic            loop_counted,
  input  wire logic [31:0]     loop_iters,
  input  wire logic            iter_exec,
  input  wire logic            loop_exit,
  input  wire logic            cond_true,
  input  wire logic            cond_at_second,
  input  wire logic            program_memory_access,
  output logic                 nop_insert,
  output logic                 irq_delay,
  output logic [1:0]           extra_iters
);

  hwl_state_e  state;
  hwl_state_e  next_state;
  logic [31:0] remain;
  logic [1:0]  nop_cnt;
  logic [1:0]  len;
  logic        counted;
  logic        short_case;

  // ==========================================================
  // classification of the loop being run
  wire is_len1    = (len == 2'h1);
  wire is_len2    = (len == 2'h2);
  // short counted loops pay two cycles to flush the pipeline
  wire start_short = loop_counted &&
                     (((loop_len == 2'h1) &&
                       ((loop_iters == 32'h1) || (loop_iters == 32'h2))) ||
                      ((loop_len == 2'h2) && (loop_iters == 32'h1)));
  wire last_iter  = (remain == 32'h1);
  wire third_last = (remain == 32'h3);

  // ==========================================================
  // next state
  always_comb
  begin
    next_state = state;
    case (state)
      HWL_IDLE: if (loop_start) next_state = HWL_RUN;
      HWL_RUN:
      begin
        if (loop_exit)
        begin
          next_state = (counted && short_case) ? HWL_NOPS : HWL_IDLE;
        end
      end
      HWL_NOPS: if (nop_cnt == 2'h1) next_state = HWL_IDLE;
      default:  next_state = HWL_IDLE;
    endcase
  end

  // ==========================================================
  // state and iteration tracking
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state      <= HWL_IDLE;
      remain     <= 32'h0;
      nop_cnt    <= 2'h0;
      len        <= 2'h0;
      counted    <= 1'b0;
      short_case <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (loop_start)
      begin
        remain     <= loop_iters;
        len        <= loop_len;
        counted    <= loop_counted;
        short_case <= start_short;
      end
      else if (iter_exec && (remain != 32'h0))
      begin
        remain <= remain - 32'h1;
      end
      // two suppressed fetches become two nop cycles
      if ((state == HWL_RUN) && (next_state == HWL_NOPS))
      begin
        nop_cnt <= `HWL_NOP_CYCLES;
      end
      else if (nop_cnt != 2'h0)
      begin
        nop_cnt <= nop_cnt - 2'h1;
      end
    end
  end

  assign nop_insert = (state == HWL_NOPS);

  // interrupt held near short loop ends and for both nop cycles
  assign irq_delay =
    ((state == HWL_RUN) && counted && short_case && last_iter) ||
    (state == HWL_NOPS) ||
    ((state == HWL_RUN) && counted && is_len1 && !short_case &&
     third_last);

  // ==========================================================
  // extra passes after a termination condition turns true
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      extra_iters <= 2'h0;
    end
    else if (cond_true && (state == HWL_RUN) && !counted)
    begin
      if (is_len1)
      begin
        // memory access in the body shortens the tail
        extra_iters <= program_memory_access ? `HWL_COND_EXTRA1P
                                             : `HWL_COND_EXTRA1;
      end
      else if (is_len2)
      begin
        extra_iters <= cond_at_second ? 2'h2 : 2'h1;
      end
      else
      begin
        extra_iters <= 2'h0; // finish this pass only
      end
    end
  end

endmodule

`default_nettype wire

// ---- hwl_loop_stacks.sv ----
// hwl_loop_stacks.sv: loop end-address stack and loop count stack with
// a classic wishbone register port, plus short loop timing.
// assumes: sequencer strobes are one-cycle pulses synchronous to clock.
`timescale 1ns/1ns
`default_nettype none

`include "hwl_defines.svh"

module hwl_loop_stacks
  import hwl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // sequencer side
  input  wire logic        loop_push,
  input  wire logic [31:0] loop_push_end,
  input  wire logic        loop_push_counted,
  input  wire logic [1:0]  loop_push_len,
  input  wire logic        loop_pop,
  input  wire logic        loop_term_pop,
  input  wire logic        iter_dec,
  input  wire logic        iter_exec,
  input  wire logic        cond_true,
  input  wire logic        cond_at_second,
  input  wire logic        program_memory_access,
  output logic             count_expired_condition,
  output logic             loop_stack_overflow_flag,
  output logic             loop_stack_empty_flag,
  output logic             overflow_irq,
  output logic             nop_insert,
  output logic             irq_delay,
  output logic [1:0]       extra_iters
);

  // ==========================================================
  // storage
  logic [31:0]            end_stack [`HWL_DEPTH];
  logic [31:0]            cnt_stack [`HWL_DEPTH];
  logic [`HWL_DEPTH-1:0]  counted_stack;
  logic [`HWL_PTR_W-1:0]  depth;
  logic [31:0]            pending;
  logic                   ovf;
  logic                   ack;
  logic [31:0]            rd_data;

  // ==========================================================
  // bus decode
  wire bus_req  = wb_cyc_i && wb_stb_i && !ack;
  wire bus_wr   = bus_req && wb_we_i;
  wire sel_end  = (wb_adr_i == `HWL_OFS_END_TOP);
  wire sel_cur  = (wb_adr_i == `HWL_OFS_CUR_CNT);
  wire sel_pend = (wb_adr_i == `HWL_OFS_PEND_CNT);
  wire sel_stat = (wb_adr_i == `HWL_OFS_STATUS);
  wire sel_dep  = (wb_adr_i == `HWL_OFS_DEPTH);

  // byte-lane merge helper for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // ==========================================================
  // stack state
  wire is_empty = (depth == `HWL_PTR_W'(0));
  wire is_full  = (depth == `HWL_PTR_W'(`HWL_DEPTH));
  wire [`HWL_PTR_W-1:0] top = depth - `HWL_PTR_W'(1);

  wire do_push  = loop_push && !is_full;
  wire push_ovf = loop_push && is_full;
  // early termination pop and explicit pop share one path
  wire do_pop   = (loop_pop || loop_term_pop) && !loop_push && !is_empty;

  wire [31:0] top_end   = is_empty ? `HWL_ALL_ONES : end_stack[top];
  wire [31:0] top_cnt   = is_empty ? `HWL_ALL_ONES : cnt_stack[top];
  wire        top_count = !is_empty && counted_stack[top];

  // bus writes to the top entries, pending and status, never moving the pointer
  wire wr_end = bus_wr && sel_end && !is_empty;
  // only a running counted loop accepts a new count
  wire wr_cur = bus_wr && sel_cur && top_count;
  wire wr_pen = bus_wr && sel_pend;
  wire wr_st  = bus_wr && sel_stat;

  // ==========================================================
  // depth pointer: only push and pop move it
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      depth <= `HWL_PTR_W'(0);
    end
    else if (do_push)
    begin
      depth <= depth + `HWL_PTR_W'(1);
    end
    else if (do_pop)
    begin
      depth <= depth - `HWL_PTR_W'(1);
    end
  end

  // ==========================================================
  // per-entry storage; both stacks write at the same index
  generate
    for (genvar i = 0; i < `HWL_DEPTH; i++)
    begin : g_entry
      wire at_push = do_push && (depth == `HWL_PTR_W'(i));
      wire at_top  = !is_empty && (top == `HWL_PTR_W'(i));
      always_ff @(posedge clock)
      begin
        if (srst)
        begin
          end_stack[i]     <= 32'h0;
          cnt_stack[i]     <= 32'h0;
          counted_stack[i] <= 1'b0;
        end
        else if (at_push)
        begin
          end_stack[i]     <= loop_push_end;
          // pending becomes current, older count stays below
          cnt_stack[i]     <= pending;
          counted_stack[i] <= loop_push_counted;
        end
        else if (at_top)
        begin
          if (wr_end)
          begin
            end_stack[i] <= merge(end_stack[i], wb_dat_i, wb_sel_i);
          end
          if (wr_cur)
          begin
            cnt_stack[i] <= merge(cnt_stack[i], wb_dat_i, wb_sel_i);
          end
          else if (iter_dec && counted_stack[i])
          begin
            // zero wraps to all ones, giving 2^32 passes
            cnt_stack[i] <= cnt_stack[i] - 32'h1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // pending count register
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pending <= `HWL_PEND_RST;
    end
    else if (wr_pen)
    begin
      pending <= merge(pending, wb_dat_i, wb_sel_i);
    end
  end

  // ==========================================================
  // sticky overflow; a new overflow beats a software clear
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ovf <= 1'b0;
    end
    else if (push_ovf)
    begin
      ovf <= 1'b1;
    end
    else if (wr_st && wb_sel_i[3] && wb_dat_i[`HWL_BIT_OVF])
    begin
      ovf <= 1'b0; // write one to clear
    end
  end

  assign loop_stack_overflow_flag = ovf;
  assign overflow_irq             = ovf;      // masked by the core
  assign loop_stack_empty_flag    = is_empty;
  // expires when the executing counted loop is on its last count
  assign count_expired_condition  = top_count && (top_cnt == 32'h1);

  // ==========================================================
  // read mux; pending while full is left as is
  always_comb
  begin
    rd_data = 32'h0;
    if (sel_end)  rd_data = top_end;
    if (sel_cur)  rd_data = top_cnt;
    if (sel_pend) rd_data = pending;
    if (sel_stat)
    begin
      rd_data[`HWL_BIT_OVF]   = ovf;
      rd_data[`HWL_BIT_EMPTY] = is_empty;
    end
    if (sel_dep)  rd_data = {29'h0, depth};
  end

  // ==========================================================
  // bus answer: one wait state, unmapped reads give zero
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ack      <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      ack      <= bus_req;
      wb_dat_o <= bus_req ? rd_data : wb_dat_o;
    end
  end

  assign wb_ack_o = ack;

  // ==========================================================
  // short loop timing engine
  hwl_short_loop u_short
  (
    .clock                 (clock),
    .srst                  (srst),
    .loop_start            (do_push),
    .loop_len              (loop_push_len),
    .loop_counted          (loop_push_counted),
    .loop_iters            (pending),
    .iter_exec             (iter_exec),
    .loop_exit             (loop_term_pop),
    .cond_true             (cond_true),
    .cond_at_second        (cond_at_second),
    .program_memory_access (program_memory_access),
    .nop_insert            (nop_insert),
    .irq_delay             (irq_delay),
    .extra_iters           (extra_iters)
  );

endmodule

`default_nettype wire

// ---- hwl_loop_stacks_checker.sv ----
// hwl_loop_stacks_checker.sv: port assertions for the loop stacks.
// assumes: bound to hwl_loop_stacks; one clock, srst sync active high.
`timescale 1ns/1ns
`default_nettype none

module hwl_loop_stacks_checker
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_o,
  input  wire logic        loop_push,
  input  wire logic        loop_stack_overflow_flag,
  input  wire logic        loop_stack_empty_flag,
  input  wire logic        overflow_irq
);
  // ==========================================================
  // helpers: a taken request, and a software clear of overflow
  wire logic req;
  wire logic ovf_clr;
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ovf_clr = req & wb_we_i & (wb_adr_i == 8'h0c) & wb_sel_i[3]
                   & wb_dat_i[25];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // ==========================================================
  // bus handshake
  a_ack_answer: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");

  // ==========================================================
  // stack flags
  a_push_fills: assert property (loop_push |=> !loop_stack_empty_flag)
    else $error("empty flag after push");
  a_empty_holds: assert property
    (loop_stack_empty_flag && !loop_push |=> loop_stack_empty_flag)
    else $error("empty flag dropped without push");
  a_ovf_sticky: assert property
    (loop_stack_overflow_flag && !ovf_clr |=> loop_stack_overflow_flag)
    else $error("overflow flag lost");
  a_ovf_cause: assert property
    (!loop_stack_overflow_flag && !loop_push |=> !loop_stack_overflow_flag)
    else $error("overflow without push");
  a_ovf_not_empty: assert property
    ($rose(loop_stack_overflow_flag) |-> !loop_stack_empty_flag)
    else $error("overflow on empty stack");
  a_ovf_irq_tie: assert property (overflow_irq == loop_stack_overflow_flag)
    else $error("interrupt differs from overflow flag");
endmodule

bind hwl_loop_stacks hwl_loop_stacks_checker hwl_loop_stacks_checker_i
(
  .clock                    (clock),
  .srst                     (srst),
  .wb_cyc_i                 (wb_cyc_i),
  .wb_stb_i                 (wb_stb_i),
  .wb_we_i                  (wb_we_i),
  .wb_adr_i                 (wb_adr_i),
  .wb_sel_i                 (wb_sel_i),
  .wb_dat_i                 (wb_dat_i),
  .wb_ack_o                 (wb_ack_o),
  .loop_push                (loop_push),
  .loop_stack_overflow_flag (loop_stack_overflow_flag),
  .loop_stack_empty_flag    (loop_stack_empty_flag),
  .overflow_irq             (overflow_irq)
);

`default_nettype wire

// ---- hwl_seq_model.sv ----
// hwl_seq_model.sv: sequencer model driving push, pop and count strobes.
// assumes: one clock; strobes are one-cycle pulses after a rising edge.
`timescale 1ns/1ns
`default_nettype none

module hwl_seq_model
(
  input  wire logic        clock,
  output logic             loop_push,
  output logic [31:0]      loop_push_end,
  output logic             loop_push_counted,
  output logic [1:0]       loop_push_len,
  output logic             loop_pop,
  output logic             loop_term_pop,
  output logic             iter_dec,
  output logic             iter_exec,
  output logic             cond_true,
  output logic             cond_at_second,
  output logic             program_memory_access
);
  // quiet sequencer; short loop inputs stay idle in this model
  initial
  begin
    {iter_dec, loop_term_pop, loop_pop, loop_push} = 4'h0;
    loop_push_end = 32'h0;
    loop_push_counted = 1'b0;
    loop_push_len = 2'h3;
    {iter_exec, cond_true, cond_at_second, program_memory_access} = 4'h0;
  end

  // body length for the next push; short loops need 1 or 2
  task automatic set_len(input logic [1:0] len);
    @(posedge clock);
    loop_push_len <= len;
  endtask

  // op bits: 0 push, 1 pop, 2 termination pop, 3 decrement
  task automatic seq_op(input logic [3:0] op, input logic [31:0] end_addr,
                        input logic counted);
    @(posedge clock);
    {iter_dec, loop_term_pop, loop_pop, loop_push} <= op;
    loop_push_end <= end_addr;
    loop_push_counted <= counted;
    @(posedge clock);
    {iter_dec, loop_term_pop, loop_pop, loop_push} <= 4'h0;
    // end address is stale after the strobe, so show its inverse
    loop_push_end <= ~end_addr;
  endtask
endmodule

`default_nettype wire

// ---- hwl_loop_stacks_tb_top.sv ----
// hwl_loop_stacks_tb_top.sv: self-checking bench for the loop stacks.
// assumes: hwl_pkg compiled first; checker bound in its own file.
`timescale 1ns/1ns
`default_nettype none

`include "hwl_defines.svh"

module hwl_loop_stacks_tb_top;
  import hwl_pkg::*;
  localparam logic [31:0] ONES = `HWL_ALL_ONES;
  localparam logic [3:0]  PUSH = 4'h1;
  localparam logic [3:0]  POP  = 4'h2;
  localparam logic [3:0]  TPOP = 4'h4;
  localparam logic [3:0]  DEC  = 4'h8;

  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        lp, lpc, lpop, ltp, idec, iex, ctr, c2, pma;
  logic [31:0] lpe;
  logic [1:0]  lpl;
  logic        ovf, emp, irq;
  logic        cexp, nop, dly;
  int          n_errors = 0;
  int          total_checks = 0;

  // ==========================================================
  // clock, design and sequencer model
  always #50 clock = ~clock;

  hwl_loop_stacks hwl_loop_stacks_i
  (
    .clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .loop_push(lp), .loop_push_end(lpe), .loop_push_counted(lpc),
    .loop_push_len(lpl), .loop_pop(lpop), .loop_term_pop(ltp),
    .iter_dec(idec), .iter_exec(iex), .cond_true(ctr),
    .cond_at_second(c2), .program_memory_access(pma),
    .count_expired_condition(cexp), .loop_stack_overflow_flag(ovf),
    .loop_stack_empty_flag(emp), .overflow_irq(irq), .nop_insert(nop),
    .irq_delay(dly), .extra_iters()
  );

  hwl_seq_model hwl_seq_model_i
  (
    .clock(clock), .loop_push(lp), .loop_push_end(lpe),
    .loop_push_counted(lpc), .loop_push_len(lpl), .loop_pop(lpop),
    .loop_term_pop(ltp), .iter_dec(idec), .iter_exec(iex),
    .cond_true(ctr), .cond_at_second(c2), .program_memory_access(pma)
  );

  // ==========================================================
  // comparison, bus cycles and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled high, then released
  task automatic wb_acc(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50)
      chk(32'h0, 32'h1);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_acc(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_acc(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  function automatic logic [31:0] st(input logic e, input logic o);
    st = 32'h0;
    st[`HWL_BIT_EMPTY] = e;
    st[`HWL_BIT_OVF] = o;
  endfunction

  task automatic results();
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog: the tests need well under 2000 cycles
  initial
  begin
    #2_000_000;
    n_errors++;
    results();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    rd(`HWL_OFS_END_TOP, ONES);
    rd(`HWL_OFS_CUR_CNT, ONES);
    rd(`HWL_OFS_STATUS, st(1'b1, 1'b0));
    wr(`HWL_OFS_CUR_CNT, 32'h5);
    rd(`HWL_OFS_CUR_CNT, ONES);
    // first counted loop
    wr(`HWL_OFS_PEND_CNT, 32'h5);
    rd(`HWL_OFS_PEND_CNT, 32'h5);
    hwl_seq_model_i.seq_op(PUSH, 32'h1000, 1'b1);
    rd(`HWL_OFS_END_TOP, 32'h1000);
    rd(`HWL_OFS_CUR_CNT, 32'h5);
    rd(`HWL_OFS_STATUS, st(1'b0, 1'b0));
    rd(`HWL_OFS_DEPTH, 32'h1);
    repeat (2) hwl_seq_model_i.seq_op(DEC, 32'h0, 1'b0);
    rd(`HWL_OFS_CUR_CNT, 32'h3);
    wr(`HWL_OFS_CUR_CNT, 32'h9);
    rd(`HWL_OFS_CUR_CNT, 32'h9);
    chk({31'h0, cexp}, 32'h0);
    wr(`HWL_OFS_CUR_CNT, 32'h1);
    chk({31'h0, cexp}, 32'h1);
    wr(`HWL_OFS_CUR_CNT, 32'h9);
    wr(`HWL_OFS_END_TOP, 32'h2222);
    rd(`HWL_OFS_END_TOP, 32'h2222);
    rd(`HWL_OFS_DEPTH, 32'h1);
    // nested loop with a zero count, then early termination
    wr(`HWL_OFS_PEND_CNT, 32'h0);
    hwl_seq_model_i.seq_op(PUSH, 32'h3000, 1'b1);
    rd(`HWL_OFS_CUR_CNT, 32'h0);
    rd(`HWL_OFS_DEPTH, 32'h2);
    hwl_seq_model_i.seq_op(TPOP, 32'h0, 1'b0);
    rd(`HWL_OFS_END_TOP, 32'h2222);
    rd(`HWL_OFS_CUR_CNT, 32'h9);
    hwl_seq_model_i.seq_op(POP, 32'h0, 1'b0);
    rd(`HWL_OFS_CUR_CNT, ONES);
    // seven pushes: the last overflows and is not stored
    for (int i = 0; i < 7; i++)
      hwl_seq_model_i.seq_op(PUSH, 32'h100 + i, 1'b1);
    rd(`HWL_OFS_DEPTH, 32'h6);
    rd(`HWL_OFS_END_TOP, 32'h105);
    rd(`HWL_OFS_STATUS, st(1'b0, 1'b1));
    repeat (7) hwl_seq_model_i.seq_op(POP, 32'h0, 1'b0);
    rd(`HWL_OFS_DEPTH, 32'h0);
    rd(`HWL_OFS_STATUS, st(1'b1, 1'b1));
    wr(`HWL_OFS_STATUS, st(1'b0, 1'b1));
    rd(`HWL_OFS_STATUS, st(1'b1, 1'b0));
    rd(8'h14, 32'h0);
    // one-long counted loop run twice: two nop cycles, irq held
    wr(`HWL_OFS_PEND_CNT, 32'h2);
    hwl_seq_model_i.set_len(2'h1);
    hwl_seq_model_i.seq_op(PUSH, 32'h40, 1'b1);
    hwl_seq_model_i.seq_op(TPOP, 32'h0, 1'b0);
    @(posedge clock);
    chk({30'h0, nop, dly}, 32'h3);
    @(posedge clock);
    chk({30'h0, nop, dly}, 32'h3);
    @(posedge clock);
    chk({30'h0, nop, dly}, 32'h0);
    results();
  end
endmodule

`default_nettype wire
